// *** pin_pull_and_polarity_config.sv ***
// smbus-reached bank of pull and polarity settings for three control pins
// assumes the host keeps to smbus bit timing, slow against mclk
`timescale 1ns/1ps
module pin_pull_and_polarity_config
    import pin_cfg_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = pin_cfg_pkg::SLAVE_ADDR_DEF
)
(
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   srst,
    // smbus pins, open drain data
    input  wire logic                   scl_in,
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe_n,
    // control pins watched by the bank
    input  wire logic                   output_enable_first,
    input  wire logic                   output_enable_second,
    input  wire logic                   powergood_powerdown_input,
    // pad termination controls
    output pin_cfg_pkg::pad_ctrl_s      pad_ctrl,
    // qualified results for the output and power logic
    output logic                        first_output_enabled,
    output logic                        second_output_enabled,
    output logic                        powerdown_request
);
    import pin_cfg_pkg::*;

    // ****************
    // state
    // ****************
    typedef struct packed {
        smb_phase_e phase;     // transfer phase
        logic [3:0] bitcnt;    // bits moved in this byte
        logic [7:0] shreg;     // shift register
        logic       rd_mode;   // current transfer reads
        logic [7:0] ptr;       // register pointer, auto-increments
        cfg_regs_s  regs;      // the register bank
        logic       oe_n;      // sda release when high
        pad_ctrl_s  pads;      // registered pad controls
        logic       en1;       // first output enabled
        logic       en2;       // second output enabled
        logic       pdn;       // power down asked
    } top_state_s;

    top_state_s cur_ff;
    top_state_s nxt_ff;

    logic scl_rise;            // one-cycle events from the line watcher
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [7:0] rd_byte;       // byte at the pointer

    // ****************
    // line events
    // ****************
    smb_line_events u_events
    (
        .mclk      (mclk),
        .srst      (srst),
        .scl_in    (scl_in),
        .sda_in    (sda_in),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .bus_start (bus_start),
        .bus_stop  (bus_stop)
    );

    // ****************
    // register access functions
    // ****************
    // read one byte; fixed bits come back from the stored defaults
    function automatic logic [7:0] read_reg(input logic [7:0] a, input cfg_regs_s r);
        logic [7:0] v;
        v = UNMAPPED_READ;
        case (a)
            ENABLE0_PULL_SELECT_OFS:   v = r.enable0_pull_select;
            ENABLE1_PULL_SELECT_OFS:   v = r.enable1_pull_select;
            POWERGOOD_PULL_SELECT_OFS: v = r.powergood_pull_select;
            ENABLE_POLARITY_OFS:       v = r.enable_polarity;
            POWERGOOD_POLARITY_OFS:    v = r.powergood_polarity;
            default:                   v = UNMAPPED_READ;
        endcase
        return v;
    endfunction : read_reg

    // merge writable bits only, reserved bits keep their value
    function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] wr_v,
                                         input logic [7:0] mask);
        return (old_v & ~mask) | (wr_v & mask);
    endfunction : merge

    assign rd_byte = read_reg(cur_ff.ptr, cur_ff.regs);

    // ****************
    // next state
    // ****************
    always_comb
    begin
        nxt_ff = cur_ff;
        if (bus_start)
        begin
            // start or repeated start: always listen for an address
            nxt_ff.phase  = PH_ADDR;
            nxt_ff.bitcnt = '0;
            nxt_ff.oe_n   = 1'b1;
        end
        else if (bus_stop)
        begin
            nxt_ff.phase = PH_IDLE;
            nxt_ff.oe_n  = 1'b1;
        end
        else if (scl_rise)
        begin
            case (cur_ff.phase)
                PH_ADDR, PH_CMD, PH_WR:
                begin
                    // sample on rising clock
                    nxt_ff.shreg  = {cur_ff.shreg[6:0], sda_in};
                    nxt_ff.bitcnt = cur_ff.bitcnt + 4'h1;
                end
                PH_RD_ACK:
                begin
                    // master ack low asks for another byte
                    nxt_ff.phase = sda_in ? PH_IDLE : PH_RD_NEXT;
                end
                default:
                begin
                    nxt_ff.phase = cur_ff.phase;
                end
            endcase
        end
        else if (scl_fall)
        begin
            case (cur_ff.phase)
                PH_ADDR:
                begin
                    if (cur_ff.bitcnt == BITS_PER_BYTE)
                    begin
                        if (cur_ff.shreg[7:1] == SLAVE_ADDR)
                        begin
                            nxt_ff.rd_mode = cur_ff.shreg[0];
                            nxt_ff.oe_n    = 1'b0;   // ack
                            nxt_ff.phase   = PH_ADDR_ACK;
                        end
                        else
                        begin
                            // not ours: stay off the bus until next start
                            nxt_ff.phase = PH_IDLE;
                        end
                    end
                end
                PH_CMD:
                begin
                    if (cur_ff.bitcnt == BITS_PER_BYTE)
                    begin
                        nxt_ff.ptr   = cur_ff.shreg;
                        nxt_ff.oe_n  = 1'b0;
                        nxt_ff.phase = PH_CMD_ACK;
                    end
                end
                PH_WR:
                begin
                    if (cur_ff.bitcnt == BITS_PER_BYTE)
                    begin
                        // unmapped writes are acked and dropped
                        case (cur_ff.ptr)
                            ENABLE0_PULL_SELECT_OFS:
                                nxt_ff.regs.enable0_pull_select = merge(
                                    cur_ff.regs.enable0_pull_select, cur_ff.shreg,
                                    ENABLE0_PULL_WMASK);
                            ENABLE1_PULL_SELECT_OFS:
                                nxt_ff.regs.enable1_pull_select = merge(
                                    cur_ff.regs.enable1_pull_select, cur_ff.shreg,
                                    ENABLE1_PULL_WMASK);
                            POWERGOOD_PULL_SELECT_OFS:
                                nxt_ff.regs.powergood_pull_select = merge(
                                    cur_ff.regs.powergood_pull_select, cur_ff.shreg,
                                    POWERGOOD_PULL_WMASK);
                            ENABLE_POLARITY_OFS:
                                nxt_ff.regs.enable_polarity = merge(
                                    cur_ff.regs.enable_polarity, cur_ff.shreg,
                                    ENABLE_POL_WMASK);
                            POWERGOOD_POLARITY_OFS:
                                nxt_ff.regs.powergood_polarity = merge(
                                    cur_ff.regs.powergood_polarity, cur_ff.shreg,
                                    POWERGOOD_POL_WMASK);
                            default:
                                nxt_ff.regs = cur_ff.regs;
                        endcase
                        nxt_ff.ptr   = cur_ff.ptr + 8'h01;
                        nxt_ff.oe_n  = 1'b0;
                        nxt_ff.phase = PH_WR_ACK;
                    end
                end
                PH_CMD_ACK, PH_WR_ACK:
                begin
                    nxt_ff.oe_n   = 1'b1;
                    nxt_ff.bitcnt = '0;
                    nxt_ff.phase  = PH_WR;
                end
                PH_ADDR_ACK, PH_RD_NEXT:
                begin
                    if ((cur_ff.phase == PH_RD_NEXT) || cur_ff.rd_mode)
                    begin
                        // load byte at pointer, drive its msb
                        nxt_ff.shreg  = rd_byte;
                        nxt_ff.oe_n   = rd_byte[7];
                        nxt_ff.bitcnt = 4'h1;
                        nxt_ff.ptr    = cur_ff.ptr + 8'h01;
                        nxt_ff.phase  = PH_RD;
                    end
                    else
                    begin
                        nxt_ff.oe_n   = 1'b1;
                        nxt_ff.bitcnt = '0;
                        nxt_ff.phase  = PH_CMD;
                    end
                end
                PH_RD:
                begin
                    if (cur_ff.bitcnt == BITS_PER_BYTE)
                    begin
                        // let the master answer
                        nxt_ff.oe_n  = 1'b1;
                        nxt_ff.phase = PH_RD_ACK;
                    end
                    else
                    begin
                        nxt_ff.oe_n   = cur_ff.shreg[3'h7 - cur_ff.bitcnt[2:0]];
                        nxt_ff.bitcnt = cur_ff.bitcnt + 4'h1;
                    end
                end
                default:
                begin
                    nxt_ff.phase = cur_ff.phase;
                end
            endcase
        end

        // pad controls come straight from the fields
        nxt_ff.pads.enable_first_termination =
            cur_ff.regs.enable0_pull_select[ENABLE0_PULL_LSB +: 2];
        nxt_ff.pads.enable_second_termination =
            cur_ff.regs.enable1_pull_select[ENABLE1_PULL_LSB +: 2];
        nxt_ff.pads.powergood_termination =
            cur_ff.regs.powergood_pull_select[POWERGOOD_PULL_LSB +: 2];

        // enabled when pin level equals the chosen active level
        nxt_ff.en1 = (output_enable_first ==
                      cur_ff.regs.enable_polarity[ENABLE0_LEVEL_BIT]);
        nxt_ff.en2 = (output_enable_second ==
                      cur_ff.regs.enable_polarity[ENABLE1_LEVEL_BIT]);
        // power down when pin level equals the chosen polarity
        nxt_ff.pdn = (powergood_powerdown_input ==
                      cur_ff.regs.powergood_polarity[POWERGOOD_LEVEL_BIT]);
    end

    // ****************
    // state register
    // ****************
    // pin results lag by one extra cycle; trades latency for clean flops
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            cur_ff.phase                      <= PH_IDLE;
            cur_ff.bitcnt                     <= '0;
            cur_ff.shreg                      <= '0;
            cur_ff.rd_mode                    <= 1'b0;
            cur_ff.ptr                        <= '0;
            cur_ff.regs.enable0_pull_select   <= ENABLE0_PULL_RESET;
            cur_ff.regs.enable1_pull_select   <= ENABLE1_PULL_RESET;
            cur_ff.regs.powergood_pull_select <= POWERGOOD_PULL_RESET;
            cur_ff.regs.enable_polarity       <= ENABLE_POL_RESET;
            cur_ff.regs.powergood_polarity    <= POWERGOOD_POL_RESET;
            cur_ff.oe_n                       <= 1'b1;
            cur_ff.pads                       <= '0;
            cur_ff.en1                        <= 1'b0;
            cur_ff.en2                        <= 1'b0;
            cur_ff.pdn                        <= 1'b0;
        end
        else
        begin
            cur_ff <= nxt_ff;
        end
    end

    // ****************
    // outputs
    // ****************
    assign sda_out               = 1'b0;   // open drain: only ever pulls low
    assign sda_oe_n              = cur_ff.oe_n;
    assign pad_ctrl              = cur_ff.pads;
    assign first_output_enabled  = cur_ff.en1;
    assign second_output_enabled = cur_ff.en2;
    assign powerdown_request     = cur_ff.pdn;

endmodule : pin_pull_and_polarity_config

// *** pin_cfg_pkg.sv ***
// constants, types and the register map of the pin pull/polarity bank
// assumes a single 20 MHz clock and an smbus fed by synchronous pins
package pin_cfg_pkg;

    // ****************
    // register offsets (smbus command codes)
    // ****************
    localparam logic [7:0] ENABLE0_PULL_SELECT_OFS   = 8'h0E;
    localparam logic [7:0] ENABLE1_PULL_SELECT_OFS   = 8'h0F;
    localparam logic [7:0] POWERGOOD_PULL_SELECT_OFS = 8'h10;
    localparam logic [7:0] ENABLE_POLARITY_OFS       = 8'h12;
    localparam logic [7:0] POWERGOOD_POLARITY_OFS    = 8'h13;

    // ****************
    // field positions
    // ****************
    localparam int ENABLE0_PULL_LSB    = 6;  // two-bit termination code
    localparam int ENABLE1_PULL_LSB    = 2;
    localparam int POWERGOOD_PULL_LSB  = 0;
    localparam int ENABLE1_LEVEL_BIT   = 5;
    localparam int ENABLE0_LEVEL_BIT   = 3;
    localparam int POWERGOOD_LEVEL_BIT = 0;

    // ****************
    // reset values (reserved bits keep their listed default)
    // ****************
    localparam logic [7:0] ENABLE0_PULL_RESET   = 8'h40;
    localparam logic [7:0] ENABLE1_PULL_RESET   = 8'h55;
    localparam logic [7:0] POWERGOOD_PULL_RESET = 8'h26;
    localparam logic [7:0] ENABLE_POL_RESET     = 8'h00;
    localparam logic [7:0] POWERGOOD_POL_RESET  = 8'h00;

    // ****************
    // host-writable masks, everything else is fixed
    // ****************
    localparam logic [7:0] ENABLE0_PULL_WMASK   = 8'hC0;
    localparam logic [7:0] ENABLE1_PULL_WMASK   = 8'h0C;
    localparam logic [7:0] POWERGOOD_PULL_WMASK = 8'h03;
    localparam logic [7:0] ENABLE_POL_WMASK     = 8'h28;
    localparam logic [7:0] POWERGOOD_POL_WMASK  = 8'h01;

    // ****************
    // misc constants and types
    // ****************
    localparam logic [7:0] UNMAPPED_READ   = 8'h00;  // answer off the map
    localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
    localparam logic [6:0] SLAVE_ADDR_DEF  = 7'h2A;  // plain default

    // termination code: 00 none, 01 pull-down, 10 pull-up, 11 both
    typedef logic [1:0] term_t;

    typedef struct packed {
        logic [7:0] enable0_pull_select;
        logic [7:0] enable1_pull_select;
        logic [7:0] powergood_pull_select;
        logic [7:0] enable_polarity;
        logic [7:0] powergood_polarity;
    } cfg_regs_s;

    typedef struct packed {
        term_t enable_first_termination;
        term_t enable_second_termination;
        term_t powergood_termination;
    } pad_ctrl_s;

    typedef enum logic [3:0] {
        PH_IDLE,
        PH_ADDR,
        PH_ADDR_ACK,
        PH_CMD,
        PH_CMD_ACK,
        PH_WR,
        PH_WR_ACK,
        PH_RD,
        PH_RD_ACK,
        PH_RD_NEXT
    } smb_phase_e;

endpackage : pin_cfg_pkg

// *** smb_line_events.sv ***
// edge and start/stop detection on the smbus clock and data pins
// assumes scl and sda already synchronous to mclk
`timescale 1ns/1ps
module smb_line_events
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // bus pins
    input  wire logic scl_in,
    input  wire logic sda_in,
    // one-cycle events
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      bus_start,
    output logic      bus_stop
);

    // ****************
    // state
    // ****************
    typedef struct packed {
        logic scl_d;   // previous clock level
        logic sda_d;   // previous data level
    } ev_state_s;

    ev_state_s cur_ff;
    ev_state_s nxt_ff;

    // previous levels follow the pins
    always_comb
    begin
        nxt_ff.scl_d = scl_in;
        nxt_ff.sda_d = sda_in;
    end

    // bus idles high, so reset to high avoids a false scl rise
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            cur_ff <= '1;
        end
        else
        begin
            cur_ff <= nxt_ff;
        end
    end

    // data moving while clock is high marks start or stop
    assign scl_rise  = scl_in & ~cur_ff.scl_d;
    assign scl_fall  = ~scl_in & cur_ff.scl_d;
    assign bus_start = scl_in & cur_ff.scl_d & cur_ff.sda_d & ~sda_in;
    assign bus_stop  = scl_in & cur_ff.scl_d & ~cur_ff.sda_d & sda_in;

endmodule : smb_line_events

// *** pin_cfg_asserts.sv ***
// concurrent checks on the ports of the pin pull/polarity bank
// assumes one mclk domain and a synchronous active-high srst
`timescale 1ns/1ps
module pin_cfg_asserts
(
    // clock and reset
    input wire logic       mclk,
    input wire logic       srst,
    // smbus pins
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_oe_n,
    // watched control pins
    input wire logic       output_enable_first,
    input wire logic       output_enable_second,
    input wire logic       powergood_powerdown_input,
    // results, pad codes seen as one flat word
    input wire logic [5:0] pad_ctrl,
    input wire logic       first_output_enabled,
    input wire logic       second_output_enabled,
    input wire logic       powerdown_request
);
    // ****************
    // clocking and named sequences
    // ****************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    // first edge out of reset
    sequence s_release;
        $fell(srst);
    endsequence
    // bus parked long enough that no write can land
    sequence s_bus_idle;
        (scl_in && sda_in)[*6];
    endsequence
    // ****************
    // assertions
    // ****************
    a_pad_reset_code: assert property (s_release |=> pad_ctrl == 6'h16)
        else $error("pad reset code");
    a_level_defaults: assert property (s_release |-> ##2
        (first_output_enabled == !output_enable_first
         && second_output_enabled == !output_enable_second
         && powerdown_request == !powergood_powerdown_input))
        else $error("default levels");
    a_first_en_track: assert property ($changed(output_enable_first) && scl_in
        |-> ##[1:3] $changed(first_output_enabled))
        else $error("first enable stuck");
    a_second_en_track: assert property ($changed(output_enable_second) && scl_in
        |-> ##[1:3] $changed(second_output_enabled))
        else $error("second enable stuck");
    a_powerdown_track: assert property ($changed(powergood_powerdown_input) && scl_in
        |-> ##[1:3] $changed(powerdown_request))
        else $error("powerdown stuck");
    a_pad_idle_hold: assert property (s_bus_idle |-> $stable(pad_ctrl))
        else $error("pad code moved");
    a_ack_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("sda drive with scl high");
    a_en_hold: assert property
        (($stable(output_enable_first) && $stable(output_enable_second) && scl_in)[*4]
        |-> $stable(first_output_enabled) && $stable(second_output_enabled))
        else $error("enable moved");
    a_pd_hold: assert property
        (($stable(powergood_powerdown_input) && scl_in)[*4] |-> $stable(powerdown_request))
        else $error("powerdown moved");
endmodule : pin_cfg_asserts

bind pin_pull_and_polarity_config pin_cfg_asserts u_asserts
(
    .mclk(mclk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_oe_n(sda_oe_n),
    .output_enable_first(output_enable_first),
    .output_enable_second(output_enable_second),
    .powergood_powerdown_input(powergood_powerdown_input),
    .pad_ctrl(pad_ctrl), .first_output_enabled(first_output_enabled),
    .second_output_enabled(second_output_enabled), .powerdown_request(powerdown_request)
);

// *** smb_host_model.sv ***
// smbus host model driving the bank's clock and data pins
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ps
module smb_host_model
(
    // clock
    input  wire logic mclk,
    // resolved data wire
    input  wire logic sda_wire,
    // host drive, data 1 releases to the pull-up
    output logic      scl_drv,
    output logic      sda_drv
);
    int unsigned qtr = 2; // quarter bit in mclk cycles, raised for a slow host
    initial
    begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    // ****************
    // bus conditions, each change just after an edge
    // ****************
    task automatic wait_q(input int unsigned n);
        repeat (n * qtr) @(posedge mclk);
    endtask : wait_q
    // start or repeated start, data falls with clock high
    task automatic start_cond();
        sda_drv <= 1'b1;
        wait_q(1);
        scl_drv <= 1'b1;
        wait_q(2);
        sda_drv <= 1'b0;
        wait_q(2);
        scl_drv <= 1'b0;
        wait_q(1);
    endtask : start_cond
    // stop, data rises with clock high; leaves the bus parked
    task automatic stop_cond();
        sda_drv <= 1'b0;
        wait_q(1);
        scl_drv <= 1'b1;
        wait_q(2);
        sda_drv <= 1'b1;
        wait_q(2);
    endtask : stop_cond
    // eight bits msb first plus the ninth; send 8'hFF to release for a read
    task automatic xfer(input logic [7:0] d, input logic ack_in,
                        output logic [7:0] q, output logic ack_seen);
        logic [8:0] tx;
        logic [8:0] rx;
        tx = {d, ack_in};
        for (int i = 8; i >= 0; i--)
        begin
            sda_drv <= tx[i];
            wait_q(1);
            scl_drv <= 1'b1;
            wait_q(1);
            rx[i] = sda_wire; // mid high phase, device data is held
            wait_q(1);
            scl_drv <= 1'b0;
            wait_q(1);
        end
        q = rx[8:1];
        ack_seen = rx[0];
    endtask : xfer
endmodule : smb_host_model

// *** tb_top.sv ***
// self-checking bench for the pin pull/polarity bank
// assumes the host model beside it and the checker bound into the design
`timescale 1ns/1ps
module tb_top;
    import pin_cfg_pkg::*;
    // ****************
    // signals and expected image
    // ****************
    logic       mclk = 1'b0;
    logic       srst = 1'b1;
    logic       scl_drv;
    logic       sda_drv;
    logic       sda_wire;
    logic       sda_out;
    logic       sda_oe_n;
    logic [2:0] pins = 3'h0; // first enable, second enable, powergood
    pad_ctrl_s  pad_ctrl;
    logic       first_output_enabled;
    logic       second_output_enabled;
    logic       powerdown_request;
    logic [7:0] exp_reg [256] = '{default: 8'h00}; // expected register image
    logic [7:0] ofs_list [7] = '{ENABLE0_PULL_SELECT_OFS, ENABLE1_PULL_SELECT_OFS,
        POWERGOOD_PULL_SELECT_OFS, 8'h11, ENABLE_POLARITY_OFS, POWERGOOD_POLARITY_OFS, 8'h14};
    int         error_cnt = 0;
    int         total_checks = 0;
    always #25 mclk = ~mclk;
    // open drain with pull-up: low whenever either side pulls
    assign sda_wire = sda_drv & (sda_oe_n | sda_out);
    smb_host_model host
    (
        .mclk(mclk), .sda_wire(sda_wire), .scl_drv(scl_drv), .sda_drv(sda_drv)
    );
    pin_pull_and_polarity_config dut
    (
        .mclk(mclk), .srst(srst), .scl_in(scl_drv), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .output_enable_first(pins[2]),
        .output_enable_second(pins[1]), .powergood_powerdown_input(pins[0]),
        .pad_ctrl(pad_ctrl), .first_output_enabled(first_output_enabled),
        .second_output_enabled(second_output_enabled), .powerdown_request(powerdown_request)
    );
    // ****************
    // compares, expectations and bus cycles
    // ****************
    task automatic chk_byte(input string name, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, e, g);
        end
    endtask : chk_byte
    task automatic chk_bit(input string name, input logic e, input logic g);
        chk_byte(name, {7'h0, e}, {7'h0, g});
    endtask : chk_bit
    // writable bits per code; off the map nothing moves
    function automatic logic [7:0] wmask(input logic [7:0] ofs);
        case (ofs)
            ENABLE0_PULL_SELECT_OFS:   return ENABLE0_PULL_WMASK;
            ENABLE1_PULL_SELECT_OFS:   return ENABLE1_PULL_WMASK;
            POWERGOOD_PULL_SELECT_OFS: return POWERGOOD_PULL_WMASK;
            ENABLE_POLARITY_OFS:       return ENABLE_POL_WMASK;
            POWERGOOD_POLARITY_OFS:    return POWERGOOD_POL_WMASK;
            default:                   return 8'h00;
        endcase
    endfunction : wmask
    task automatic check_pins();
        chk_byte("pad_ctrl", {2'h0, exp_reg[14][7:6], exp_reg[15][3:2], exp_reg[16][1:0]},
                 {2'h0, pad_ctrl});
        chk_bit("first enabled", pins[2] == exp_reg[18][3], first_output_enabled);
        chk_bit("second enabled", pins[1] == exp_reg[18][5], second_output_enabled);
        chk_bit("powerdown", pins[0] == exp_reg[19][0], powerdown_request);
    endtask : check_pins
    // pins move only with the bus parked
    task automatic set_pins(input logic [2:0] v);
        @(posedge mclk);
        pins <= v;
        repeat (6) @(posedge mclk);
        check_pins();
    endtask : set_pins
    // d lands at ofs, then at the next code by auto-increment
    task automatic reg_write(input logic [7:0] ofs, input logic [7:0] d);
        logic [7:0] q;
        logic [3:0] a;
        host.start_cond();
        host.xfer({SLAVE_ADDR_DEF, 1'b0}, 1'b1, q, a[3]);
        host.xfer(ofs, 1'b1, q, a[2]);
        host.xfer(d, 1'b1, q, a[1]);
        host.xfer(d, 1'b1, q, a[0]);
        host.stop_cond();
        chk_byte("write acks", 8'h00, {4'h0, a});
        for (logic [7:0] o = ofs; o != ofs + 8'h02; o++)
            exp_reg[o] = (exp_reg[o] & ~wmask(o)) | (d & wmask(o));
    endtask : reg_write
    // two bytes back to back, host ack between them
    task automatic reg_read(input logic [7:0] ofs);
        logic [7:0] q;
        logic [7:0] q2;
        logic [4:0] a;
        host.start_cond();
        host.xfer({SLAVE_ADDR_DEF, 1'b0}, 1'b1, q, a[4]);
        host.xfer(ofs, 1'b1, q, a[3]);
        host.start_cond();
        host.xfer({SLAVE_ADDR_DEF, 1'b1}, 1'b1, q, a[2]);
        host.xfer(8'hFF, 1'b0, q, a[1]); // ack asks for the next byte
        host.xfer(8'hFF, 1'b1, q2, a[0]); // nack closes the read
        host.stop_cond();
        chk_byte("read acks", 8'h01, {3'h0, a});
        chk_byte("read data", exp_reg[ofs], q);
        chk_byte("next read data", exp_reg[ofs + 8'h01], q2);
    endtask : reg_read
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    // ****************
    // watchdog and main sequence
    // ****************
    initial
    begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        final_report();
    end
    initial
    begin
        logic [7:0] q;
        logic       a;
        void'($urandom(32'h1649B9C9));
        exp_reg[14] = ENABLE0_PULL_RESET;
        exp_reg[15] = ENABLE1_PULL_RESET;
        exp_reg[16] = POWERGOOD_PULL_RESET;
        pins <= 3'($urandom);
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        repeat (4) @(posedge mclk);
        check_pins();
        // reset image, unmapped codes among it
        foreach (ofs_list[i])
            reg_read(ofs_list[i]);
        // every termination code, reserved bits written both ways
        for (int c = 0; c < 4; c++)
        begin
            for (int r = 0; r < 3; r++)
                reg_write(ofs_list[r], {4{2'(c)}});
            set_pins(3'($urandom));
        end
        // every active level against every pin level
        for (int p = 0; p < 8; p++)
        begin
            reg_write(ENABLE_POLARITY_OFS, {{2{p[2]}}, p[1], p[2], p[0], {3{p[2]}}});
            reg_write(POWERGOOD_POLARITY_OFS, {{7{p[2]}}, p[0]});
            for (int v = 0; v < 8; v++)
                set_pins(3'(v));
        end
        // foreign address left unanswered, unmapped write dropped
        host.start_cond();
        host.xfer({SLAVE_ADDR_DEF ^ 7'h01, 1'b0}, 1'b1, q, a);
        host.stop_cond();
        chk_bit("foreign address nack", 1'b1, a);
        reg_write(8'h11, 8'hFF);
        reg_read(8'h11);
        // random traffic, slow host in the second half
        for (int k = 0; k < 20; k++)
        begin
            host.qtr = (k < 10) ? 2 : 3;
            q = ofs_list[$urandom_range(6)];
            reg_write(q, 8'($urandom));
            reg_read(q);
            set_pins(3'($urandom));
        end
        final_report();
    end
endmodule : tb_top
